// >>> uart_far_end.sv
`timescale 1ns/100ps
module uart_far_end #(
  parameter BIT = 8
) (
  input  wire clk_sys_i,
  input  wire line_i,
  output reg  line_o
);
  initial line_o = 1'b1;
  // Stop level is a knob so a bad stop can be commanded
  task automatic send(input [9:0] d, input int n, input logic stp);
    for (int i = -1; i <= n; i++) begin
      @(posedge clk_sys_i);
      line_o <= (i < 0) ? 1'b0 : (i == n) ? stp : d[i];
      repeat (BIT - 1) @(posedge clk_sys_i);
    end
    @(posedge clk_sys_i);
    line_o <= 1'b1;
    repeat (BIT) @(posedge clk_sys_i);
  endtask
  // Centre samples after the start bit, stop bits included
  task automatic grab(input int n, output logic [11:0] d);
    d = 12'h000;
    @(negedge line_i);
    repeat (BIT / 2) @(posedge clk_sys_i);
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(posedge clk_sys_i);
      d[i] = line_i;
    end
  endtask
endmodule

// >>> uart_sfc_consts.vh
`ifndef UART_SFC_CONSTS_VH
`define UART_SFC_CONSTS_VH
`define ADR_STATUS        4'h0
`define ADR_FRAME_CTRL    4'h1
`define ADR_XCTRL         4'h2
`define ADR_DATA          4'h3
`define ADR_BAUD          4'h4
`define ST_PARITY_ERROR_FLAG           7
`define ST_NF             6
`define ST_FRAMING_ERROR_FLAG           5
`define ST_OVERRUN_FLAG           4
`define ST_RECEIVER_IDLE_FLAG          3
`define ST_RXAV           2
`define ST_TRANSMITTER_IDLE_FLAG          1
`define ST_TXE            0
`define STATUS_RESET      8'h0b
`define FC_EN             7
`define FC_NINE           6
`define FC_PEN            5
`define FC_ODD            4
`define FC_TWO            3
`define FC_BRK            2
`define FC_RX8            1
`define FC_TX8            0
`define XC_TRANSMITTER_ENABLE           0
`define XC_RECEIVER_ENABLE           1
`define XC_RIE            2
`define BAUD_RESET        16'h0043
`define OVERS             4'h8
`define BREAK_BITS        5'h0d
`endif

// >>> uart_sfc_props.sv
`timescale 1ns/100ps
module uart_sfc_props (
  input wire        clk_sys_i,
  input wire        sys_rst_i,
  input wire        clk_en_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire        wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire        tx_o,
  input wire        tx_oe_o,
  input wire        rx_oe_o,
  input wire        irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  chk_ack_next: assert property (clk_en_i && wb_cyc_i && wb_stb_i
    && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  chk_write_hold: assert property (wb_ack_o && wb_we_i
    |-> $stable(wb_dat_o)) else $error("read data moved on write");
  chk_rx_float: assert property (!rx_oe_o)
    else $error("receive pin driven");
  chk_bit_time: assert property ($fell(tx_o) |->
    (!tx_o || !tx_oe_o) [*8]) else $error("low bit too short");
  chk_reset_quiet: assert property ($fell(sys_rst_i) |-> tx_o
    && !tx_oe_o && !irq_o && wb_dat_o == 32'h0)
    else $error("outputs not at rest after reset");
  chk_tx_rest: assert property ($rose(tx_oe_o) |-> tx_o)
    else $error("line not high on enable");
  cover property ($fell(tx_o) && tx_oe_o);
  cover property ($rose(irq_o));
  cover property ($fell(tx_oe_o));
endmodule
bind uart_status_and_frame_control uart_sfc_props i_uart_sfc_props (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .tx_o(tx_o), .tx_oe_o(tx_oe_o),
  .rx_oe_o(rx_oe_o), .irq_o(irq_o));

// >>> uart_status_and_frame_control.v
// What this block does
// - Parity mismatch sets parity error flag
// - Noise flag set with data-available, never overrun
// - Bad stop bit sets framing error flag
// - Buffer overflow sets overrun, blocks further transfers
// - Status read then data access clears errors
// - Receiver idle low from start to stop
// - Data-available and error flags set together
// - Data-available clears when buffer drained after status
// - Transmitter idle when empty, line high
// - Status read then data write clears tx idle
// - Empty flag set on shift load, cleared
// - Enabling transmitter sets empty flag
// - Disabled port floats pins, resets buffers, baud
// - Disable clears transmit and receive enables, break, flags; keeps receive interrupt enable, other configuration
// - Disable aborts transfers immediately
// - Eight or nine bit words, ninth bit
// - Parity enable and even or odd type
// - One or two transmitted stop bits
// - Break after buffered data, 13 bits minimum
// - Transmit LSB first at baud rate
// - Two-word receive buffer before data register
// - Receive interrupt on overrun or data available
// - Transmitter disable aborts, resets, floats pin
//
// Added by the designer: the Wishbone slave port and the register offsets.

`timescale 1ns/100ps
`include "uart_sfc_consts.vh"

module uart_status_and_frame_control #(
  parameter BAUD_DIV_W = 16
) (
  input  wire        clk_sys_i,
  input  wire        sys_rst_i,
  input  wire        clk_en_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        rx_i,
  output reg         tx_o,
  output reg         tx_oe_o,
  output reg         rx_oe_o,
  output reg         irq_o
);
  // Software-visible state
  reg [7:0]  status;
  reg        en;
  reg        nine;
  reg        pen;
  reg        odd;
  reg        two;
  reg        brk;
  reg        rx8;
  reg        tx8;
  reg        transmitter_enable;
  reg        receiver_enable;
  reg        receive_interrupt_enable;
  reg [BAUD_DIV_W-1:0] baud_div;
  reg [BAUD_DIV_W-1:0] tick_cnt;
  reg        stat_rd;

  // Transmit side: one holding word in front of the shifter
  reg [8:0]  tx_hold;
  reg        tx_full;
  reg [1:0]  tx_st;
  reg [3:0]  tx_sub;
  reg [3:0]  tx_bit;
  reg [10:0] tx_sr;
  reg [4:0]  brk_cnt;

  // Receive side: rdata plus two buffered words
  reg [1:0]  rx_st;
  reg [3:0]  rx_sub;
  reg [3:0]  rx_bit;
  reg [9:0]  rx_sr;
  reg [2:0]  smp;
  reg        rx_noise;
  reg [11:0] fifo0;
  reg [11:0] fifo1;
  reg [1:0]  fifo_n;
  reg [8:0]  rdata;

  localparam TX_IDLE = 2'b00;
  localparam TX_SEND = 2'b01;
  localparam TX_BRK  = 2'b10;
  localparam RX_IDLE = 2'b00;
  localparam RX_RUN  = 2'b01;

  function parity9;
    input [8:0] d;
    input       nb;
    input       od;
    begin
      parity9 = (^d[7:0]) ^ (nb & d[8]) ^ od;
    end
  endfunction

  // Last bit cell of a frame, start bit counted as cell 0
  function [3:0] last_cell;
    input [3:0] len;
    input       extra;
    begin
      last_cell = len + {3'b000, extra} + 4'h1;
    end
  endfunction

  // Bus decode: one access per ack
  wire acc     = wb_cyc_i & wb_stb_i & ~wb_ack_o & clk_en_i;
  wire wr      = acc & wb_we_i & wb_sel_i[0];
  wire rd      = acc & ~wb_we_i;
  wire tick    = (tick_cnt == {BAUD_DIV_W{1'b0}});
  wire dat_rd  = rd & (wb_adr_i == `ADR_DATA);
  wire dat_wr  = wr & (wb_adr_i == `ADR_DATA);
  wire dat_acc = dat_rd | dat_wr;
  wire fc_wr   = wr & (wb_adr_i == `ADR_FRAME_CTRL);
  wire xc_wr   = wr & (wb_adr_i == `ADR_XCTRL);
  wire tx_on   = en & transmitter_enable;
  wire rx_on   = en & receiver_enable;
  wire [3:0] nbits = nine ? 4'd9 : 4'd8;
  wire [3:0] rx_len = nbits + {3'b000, pen};
  wire maj = (smp[0] & smp[1]) | (smp[1] & smp[2]) | (smp[0] & smp[2]);
  wire rx_done = rx_on & (rx_st == RX_RUN) & tick & (rx_sub == 4'd7)
                 & (rx_bit == last_cell(rx_len, 1'b0));
  wire fifo_pop = dat_rd & stat_rd & (fifo_n != 2'd0);
  wire [8:0] rdat_w = {rx_sr[8] & nine, nine ? rx_sr[7:0] :
                      rx_sr[8:1]};

  // Receive result, stop-bit samples included in the noise check
  wire        noise_now = rx_noise | (~&smp & |smp);
  wire        parity_error_flag_now  = pen & (parity9(rdat_w, nine, odd) != rx_sr[9]);
  wire [11:0] rx_word   = {noise_now, ~maj, parity_error_flag_now, rdat_w};
  // A lost word never shows up as noise, only as overrun
  wire        rx_ovr    = status[`ST_OVERRUN_FLAG] | (fifo_n == 2'd2 & ~fifo_pop);
  wire        rx_push   = rx_done & ~rx_ovr
                          & ((fifo_n != 2'd0) | status[`ST_RXAV]);

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      status <= `STATUS_RESET;
      {en, nine, pen, odd, two, brk, rx8, tx8} <= 8'h00;
      {transmitter_enable, receiver_enable, receive_interrupt_enable} <= 3'b000;
      baud_div <= `BAUD_RESET;
      tick_cnt <= {BAUD_DIV_W{1'b0}};
      stat_rd <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      tx_hold <= 9'h000;
      tx_full <= 1'b0;
      tx_st <= TX_IDLE;
      tx_sub <= 4'h0;
      tx_bit <= 4'h0;
      tx_sr <= 11'h7ff;
      brk_cnt <= 5'h00;
      rx_st <= RX_IDLE;
      rx_sub <= 4'h0;
      rx_bit <= 4'h0;
      rx_sr <= 10'h000;
      smp <= 3'b111;
      rx_noise <= 1'b0;
      fifo0 <= 12'h000;
      fifo1 <= 12'h000;
      fifo_n <= 2'd0;
      rdata <= 9'h000;
      tx_o <= 1'b1;
      tx_oe_o <= 1'b0;
      rx_oe_o <= 1'b0;
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      wb_ack_o <= acc;
      if (rd) begin
        case (wb_adr_i)
          `ADR_STATUS:     wb_dat_o <= {24'h0, status};
          `ADR_FRAME_CTRL: wb_dat_o <= {24'h0, en, nine, pen, odd, two,
                                        brk, rx8, 1'b0};
          `ADR_XCTRL:      wb_dat_o <= {29'h0, receive_interrupt_enable, receiver_enable, transmitter_enable};
          `ADR_DATA:       wb_dat_o <= {24'h0, rdata[7:0]};
          `ADR_BAUD:       wb_dat_o <= {{(32-BAUD_DIV_W){1'b0}}, baud_div};
          default:         wb_dat_o <= 32'h0;
        endcase
      end
      if (rd & (wb_adr_i == `ADR_STATUS))
        stat_rd <= 1'b1;
      else if (dat_acc)
        stat_rd <= 1'b0;
      if (wr & (wb_adr_i == `ADR_BAUD))
        baud_div <= wb_dat_i[BAUD_DIV_W-1:0];
      if (fc_wr) begin
        {en, nine, pen, odd, two, brk, tx8} <=
          {wb_dat_i[7:2], wb_dat_i[0]};
      end
      if (xc_wr) begin
        transmitter_enable <= wb_dat_i[`XC_TRANSMITTER_ENABLE];
        receiver_enable <= wb_dat_i[`XC_RECEIVER_ENABLE];
        receive_interrupt_enable  <= wb_dat_i[`XC_RIE];
        if (wb_dat_i[`XC_TRANSMITTER_ENABLE] & ~transmitter_enable)
          status[`ST_TXE] <= 1'b1;
      end
      irq_o <= receive_interrupt_enable & (status[`ST_OVERRUN_FLAG] | status[`ST_RXAV]);
      tx_oe_o <= tx_on;
      rx_oe_o <= 1'b0;
      tick_cnt <= tick ? baud_div : tick_cnt - 1'b1;

      // Errors clear on status-then-data; new events below win
      if (dat_acc & stat_rd)
        status[7:4] <= 4'h0;

      // A write clears the flags only after a status read
      if (dat_wr) begin
        tx_hold <= {tx8, wb_dat_i[7:0]};
        tx_full <= 1'b1;
        if (stat_rd & status[`ST_TXE])
          status[`ST_TXE] <= 1'b0;
        if (stat_rd & status[`ST_TRANSMITTER_IDLE_FLAG])
          status[`ST_TRANSMITTER_IDLE_FLAG] <= 1'b0;
      end

      // Transmitter: holding word first, break only when empty
      case (tx_st)
        TX_IDLE: begin
          tx_o <= 1'b1;
          if (tx_on & tx_full & ~dat_wr) begin
            tx_sr <= nine ?
              {1'b1, tx_hold, 1'b0} :
              {2'b11, tx_hold[7:0], 1'b0};
            if (pen) begin
              if (nine)
                tx_sr <= {parity9(tx_hold, 1'b1, odd), tx_hold, 1'b0};
              else
                tx_sr <= {1'b1, parity9(tx_hold, 1'b0, odd),
                          tx_hold[7:0], 1'b0};
            end
            tx_full <= 1'b0;
            status[`ST_TXE] <= 1'b1;
            status[`ST_TRANSMITTER_IDLE_FLAG] <= 1'b0;
            tx_bit <= 4'h0;
            tx_sub <= 4'h0;
            tx_st <= TX_SEND;
          end else if (tx_on & brk & ~tx_full) begin
            brk_cnt <= 5'h00;
            tx_sub <= 4'h0;
            status[`ST_TRANSMITTER_IDLE_FLAG] <= 1'b0;
            tx_st <= TX_BRK;
          end else if (~tx_full & ~dat_wr) begin
            status[`ST_TRANSMITTER_IDLE_FLAG] <= status[`ST_TXE];
          end
        end
        TX_SEND: begin
          tx_o <= tx_sr[0];
          if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == `OVERS - 4'h1) begin
              tx_sub <= 4'h0;
              tx_sr <= {1'b1, tx_sr[10:1]};
              tx_bit <= tx_bit + 4'h1;
              if (tx_bit == last_cell(rx_len, two))
                tx_st <= TX_IDLE;
            end
          end
        end
        TX_BRK: begin
          tx_o <= 1'b0;
          if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == `OVERS - 4'h1) begin
              tx_sub <= 4'h0;
              if (brk_cnt != `BREAK_BITS)
                brk_cnt <= brk_cnt + 5'h01;
            end
          end
          if ((brk_cnt == `BREAK_BITS) & ~brk)
            tx_st <= TX_IDLE;
        end
        default: tx_st <= TX_IDLE;
      endcase
      if (~tx_on) begin
        tx_st <= TX_IDLE;
        tx_full <= 1'b0;
        tx_o <= 1'b1;
      end

      // Receiver
      case (rx_st)
        RX_IDLE: begin
          status[`ST_RECEIVER_IDLE_FLAG] <= 1'b1;
          if (rx_on & ~rx_i) begin
            rx_st <= RX_RUN;
            status[`ST_RECEIVER_IDLE_FLAG] <= 1'b0;
            rx_sub <= 4'h0;
            rx_bit <= 4'h0;
            rx_noise <= 1'b0;
          end
        end
        RX_RUN: if (tick) begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub >= 4'd2 && rx_sub <= 4'd4)
            smp <= {smp[1:0], rx_i};
          if (rx_sub == 4'd7) begin
            if (~&smp & |smp)
              rx_noise <= 1'b1;
            if (rx_bit != 4'h0 && rx_bit <= rx_len)
              // No parity: bit 9 stays free so data lands low
              rx_sr <= pen ? {maj, rx_sr[9:1]} :
                             {1'b0, maj, rx_sr[8:1]};
            rx_bit <= rx_bit + 4'h1;
          end
          if (rx_sub == `OVERS - 4'h1)
            rx_sub <= 4'h0;
          if (rx_done)
            rx_st <= RX_IDLE;
        end
        default: rx_st <= RX_IDLE;
      endcase

      if (rx_done) begin
        if (rx_ovr)
          status[`ST_OVERRUN_FLAG] <= 1'b1;
        else if (~rx_push) begin
          rdata <= rdat_w;
          rx8 <= rdat_w[8];
          status[`ST_RXAV] <= 1'b1;
          status[`ST_NF] <= noise_now;
          status[`ST_FRAMING_ERROR_FLAG] <= ~maj;
          status[`ST_PARITY_ERROR_FLAG] <= parity_error_flag_now;
        end else begin
          fifo1 <= rx_word;
          // With one word left and popped, the new word is next
          if (fifo_n == 2'd0 | (fifo_n == 2'd1 & fifo_pop))
            fifo0 <= rx_word;
          fifo_n <= fifo_pop ? fifo_n : fifo_n + 2'd1;
        end
      end
      // The read that clears overrun also moves the next word up
      if (fifo_pop) begin
        rdata <= fifo0[8:0];
        rx8 <= fifo0[8];
        status[`ST_NF] <= fifo0[11];
        status[`ST_FRAMING_ERROR_FLAG] <= fifo0[10];
        status[`ST_PARITY_ERROR_FLAG] <= fifo0[9];
        if (~(rx_push & (fifo_n == 2'd1)))
          fifo0 <= fifo1;
        if (~rx_push)
          fifo_n <= fifo_n - 2'd1;
      end else if (dat_rd & stat_rd & status[`ST_RXAV] & (fifo_n == 2'd0)
                   & ~rx_done)
        status[`ST_RXAV] <= 1'b0;
      if (~rx_on) begin
        rx_st <= RX_IDLE;
        status[`ST_RECEIVER_IDLE_FLAG] <= 1'b1;
        fifo_n <= 2'd0;
      end

      // Port disable: abort, clear flags, break and transmit/receive enables, keep other configuration
      if (~en) begin
        tx_st <= TX_IDLE;
        rx_st <= RX_IDLE;
        tx_full <= 1'b0;
        fifo_n <= 2'd0;
        tick_cnt <= {BAUD_DIV_W{1'b0}};
        status <= `STATUS_RESET;
        transmitter_enable <= 1'b0;
        receiver_enable <= 1'b0;
        brk <= 1'b0;
        tx_oe_o <= 1'b0;
      end
    end
  end
endmodule

// >>> uart_status_and_frame_control_test.sv
`timescale 1ns/100ps
`include "uart_sfc_consts.vh"
module uart_status_and_frame_control_test;
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  wire  [31:0] rdat;
  wire         ack, rx, tx, tx_oe, irq;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cyc_count = 0;
  int          n_low;
  logic [7:0]  v;
  logic [11:0] fr;
  uart_status_and_frame_control i_uart_status_and_frame_control (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_i(rx), .tx_o(tx), .tx_oe_o(tx_oe), .rx_oe_o(), .irq_o(irq));
  uart_far_end i_uart_far_end (.clk_sys_i(clk_sys_i), .line_i(tx),
    .line_o(rx));
  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 20000) begin
      n_errors = n_errors + 1;
      end_sim;
    end
  end
  task automatic bus(input [3:0] a, input w, input [7:0] d);
    @(posedge clk_sys_i);
    cyc <= 1'b1;
    adr <= a;
    we <= w;
    wdat <= {24'h0, d};
    do @(posedge clk_sys_i); while (ack !== 1'b1);
    v = rdat[7:0];
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic cmp(input string nm, input [11:0] e, input [11:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input [3:0] a, input [7:0] e, input string nm);
    bus(a, 1'b0, 8'h00);
    cmp(nm, e, v);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rdc(`ADR_STATUS, 8'h0b, "status reset");
    rdc(4'hf, 8'h00, "unmapped");
    bus(`ADR_BAUD, 1'b1, 8'h00);
    bus(`ADR_FRAME_CTRL, 1'b1, 8'hb8);
    bus(`ADR_XCTRL, 1'b1, 8'h07);
    rdc(`ADR_STATUS, 8'h0b, "status enabled");
    fork
      begin
        i_uart_far_end.grab(11, fr);
        cmp("frame a", 12'h7a5, fr);
        i_uart_far_end.grab(11, fr);
        cmp("frame b", 12'h73c, fr);
      end
      begin
        bus(`ADR_STATUS, 1'b0, 8'h00);
        bus(`ADR_DATA, 1'b1, 8'ha5);
        bus(`ADR_STATUS, 1'b0, 8'h00);
        cmp("tx idle", 12'h0, {4'h0, v & 8'h02});
        bus(`ADR_DATA, 1'b1, 8'h3c);
      end
    join
    repeat (16) @(posedge clk_sys_i);
    rdc(`ADR_STATUS, 8'h0b, "status done");
    for (int o = 0; o < 2; o++) begin
      bus(`ADR_FRAME_CTRL, 1'b1, {3'b101, o[0], 4'h0});
      i_uart_far_end.send({1'b0, ~o[0], 8'h81}, 9, 1'b1);
      cmp("irq", 12'h1, {11'h0, irq});
      rdc(`ADR_STATUS, 8'h8f, "parity err");
      rdc(`ADR_DATA, 8'h81, "rx data");
      rdc(`ADR_STATUS, 8'h0b, "cleared");
    end
    bus(`ADR_FRAME_CTRL, 1'b1, 8'h80);
    i_uart_far_end.send(10'h055, 8, 1'b0);
    rdc(`ADR_STATUS, 8'h2f, "framing err");
    rdc(`ADR_DATA, 8'h55, "rx framed");
    for (int k = 0; k < 5; k++)
      i_uart_far_end.send({2'b00, 8'h10 + k[7:0]}, 8, 1'b1);
    rdc(`ADR_STATUS, 8'h1f, "overrun");
    rdc(`ADR_DATA, 8'h10, "oldest word");
    for (int k = 1; k < 3; k++) begin
      rdc(`ADR_STATUS, 8'h0f, "rx pending");
      rdc(`ADR_DATA, 8'h10 + k[7:0], "buffered word");
    end
    rdc(`ADR_STATUS, 8'h0b, "drained");
    bus(`ADR_FRAME_CTRL, 1'b1, 8'hc1);
    fork
      i_uart_far_end.grab(10, fr);
      begin
        bus(`ADR_STATUS, 1'b0, 8'h00);
        bus(`ADR_DATA, 1'b1, 8'h5a);
      end
    join
    cmp("nine tx", 12'h35a, fr);
    i_uart_far_end.send(10'h166, 9, 1'b1);
    bus(`ADR_FRAME_CTRL, 1'b0, 8'h00);
    cmp("ninth rx", 12'h2, {4'h0, v & 8'h02});
    bus(`ADR_STATUS, 1'b0, 8'h00);
    bus(`ADR_FRAME_CTRL, 1'b1, 8'hd9);
    bus(`ADR_STATUS, 1'b0, 8'h00);
    bus(`ADR_DATA, 1'b1, 8'h5a);
    repeat (30) @(posedge clk_sys_i);
    bus(`ADR_FRAME_CTRL, 1'b1, 8'h59);
    @(posedge clk_sys_i);
    cmp("tx drive", 12'h0, {11'h0, tx_oe});
    rdc(`ADR_STATUS, 8'h0b, "status off");
    rdc(`ADR_XCTRL, 8'h04, "xctrl off");
    bus(`ADR_FRAME_CTRL, 1'b0, 8'h00);
    cmp("ctrl kept", 12'h58, {4'h0, v & 8'hfd});
    bus(`ADR_FRAME_CTRL, 1'b1, 8'h80);
    bus(`ADR_XCTRL, 1'b1, 8'h07);
    n_low = 0;
    fork
      repeat (300) @(posedge clk_sys_i) n_low += (tx === 1'b0);
      begin
        bus(`ADR_FRAME_CTRL, 1'b1, 8'h84);
        bus(`ADR_FRAME_CTRL, 1'b1, 8'h80);
      end
    join
    cmp("break", 12'h1, {11'h0, n_low >= 104 && n_low < 120});
    end_sim;
  end
endmodule
